/* File: hdl/cursor_pkg.sv */
package cursor_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_EXT_ENABLE = 8'h00;
  localparam logic [7:0] OFF_CURSOR_CONTROL = 8'h04;
  localparam logic [7:0] OFF_CURSOR_POSITION = 8'h08;
  localparam logic [7:0] OFF_CURSOR_DATA = 8'h0C;
  localparam logic [7:0] OFF_ACTIVE_POSITION = 8'h10;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int EXT_EN_BIT = 1;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SMALL_BIT = 1;
  localparam int CTRL_SEL_LSB = 2;
  localparam int CTRL_PTR_LSB = 8;
  localparam int POS_X_LSB = 0;
  localparam int POS_Y_LSB = 16;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int COORD_W = 11;
  localparam int PIX_W = 16;
  localparam int RAM_AW = 8;
  localparam int RAM_WORDS = 256;
  localparam logic [6:0] LARGE_SIDE = 7'h40;
  localparam logic [6:0] SMALL_SIDE = 7'h20;

  // ------------------------------------------------------------
  // Reset values and colours
  // ------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [PIX_W-1:0] COLOUR_ZERO = 16'h0000;
  localparam logic [PIX_W-1:0] COLOUR_ONE = 16'hFFFF;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACCESS = 2'b10
  } bus_state_e;

endpackage : cursor_pkg

/* File: hdl/cursor_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module cursor_ram import cursor_pkg::*; (
  input wire logic clk,
  cursor_ram_if.mem ram
);
  logic [31:0] store [RAM_WORDS];

  // ------------------------------------------------------------
  // One write port, two registered read ports
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ram.wrEn) begin
      store[ram.wrAddr] <= ram.wrData;
    end
    ram.rdAnd <= store[ram.rdAddrAnd];
    ram.rdXor <= store[ram.rdAddrXor];
  end
endmodule : cursor_ram
`default_nettype wire

/* File: hdl/cursor_ram_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cursor_ram_if;
  import cursor_pkg::*;
  logic wrEn;
  logic [RAM_AW-1:0] wrAddr;
  logic [31:0] wrData;
  logic [RAM_AW-1:0] rdAddrAnd;
  logic [RAM_AW-1:0] rdAddrXor;
  logic [31:0] rdAnd;
  logic [31:0] rdXor;
  modport user (output wrEn, wrAddr, wrData, rdAddrAnd, rdAddrXor, input rdAnd, rdXor);
  modport mem (input wrEn, wrAddr, wrData, rdAddrAnd, rdAddrXor, output rdAnd, rdXor);
endinterface : cursor_ram_if
`default_nettype wire

/* File: hdl/hardware_cursor_overlay.sv */
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module hardware_cursor_overlay import cursor_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic vsync,
  input wire logic [COORD_W-1:0] hPos,
  input wire logic [COORD_W-1:0] vPos,
  input wire logic [PIX_W-1:0] gfxPixel,
  input wire logic [PIX_W-1:0] videoPixel,
  input wire logic videoActive,
  output logic [PIX_W-1:0] pixelOut
);

  cursor_ram_if ramBus ();

  cursor_ram ramInst (
    .clk(clk),
    .ram(ramBus)
  );

  // ------------------------------------------------------------
  // Bus and register state
  // ------------------------------------------------------------
  bus_state_e busState_q, busState_d;
  logic [7:0] addr_q, addr_d;
  logic write_q, write_d;
  logic [2:0] size_q, size_d;
  logic hreadyout_q, hreadyout_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic hresp_q;
  logic [31:0] ext_q, ext_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] pos_q, pos_d;
  logic [31:0] laneMask;
  logic [RAM_AW-1:0] ptr;
  logic [RAM_AW-1:0] ptrNext;
  logic accessOk;

  // ------------------------------------------------------------
  // Frame and pixel state
  // ------------------------------------------------------------
  logic vsyncPrev_q;
  logic [31:0] activePos_q, activePos_d;
  logic [1:0] activeSel_q, activeSel_d;
  logic inside_q, inside_d;
  logic [4:0] bitIdx_q, bitIdx_d;
  logic [PIX_W-1:0] base_q, base_d;
  logic [PIX_W-1:0] pixelOut_q, pixelOut_d;
  logic [COORD_W:0] dx;
  logic [COORD_W:0] dy;
  logic [6:0] side;
  logic curSmall;
  logic andBit;
  logic xorBit;

  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = hresp_q;
  assign pixelOut = pixelOut_q;
  assign ptr = ctrl_q[CTRL_PTR_LSB +: RAM_AW];
  assign curSmall = ctrl_q[CTRL_SMALL_BIT];

  // ------------------------------------------------------------
  // Byte lanes of the data phase
  // ------------------------------------------------------------
  always_comb begin
    case (size_q)
      3'h0: laneMask = 32'h0000_00FF << {addr_q[1:0], 3'h0};
      3'h1: laneMask = 32'h0000_FFFF << {addr_q[1], 4'h0};
      default: laneMask = 32'hFFFF_FFFF;
    endcase
  end

  // ------------------------------------------------------------
  // Pointer step with plane jump
  // ------------------------------------------------------------
  always_comb begin
    if (curSmall && !ptr[RAM_AW-1] && ptr[4:0] == 5'h1F) begin
      ptrNext = {1'b1, ptr[6:5], 5'h00};
    end else begin
      ptrNext = ptr + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // AHB-Lite slave and registers
  // ------------------------------------------------------------
  always_comb begin
    busState_d = busState_q;
    addr_d = addr_q;
    write_d = write_q;
    size_d = size_q;
    hreadyout_d = hreadyout_q;
    hrdata_d = hrdata_q;
    ext_d = ext_q;
    ctrl_d = ctrl_q;
    pos_d = pos_q;
    ramBus.wrEn = 1'b0;
    ramBus.wrAddr = ptr;
    ramBus.wrData = hwdata;
    accessOk = ({addr_q[7:2], 2'h0} == OFF_EXT_ENABLE) || ext_q[EXT_EN_BIT];
    case (busState_q)
      BUS_IDLE: begin
        if (hsel && htrans[1] && hready) begin
          addr_d = {haddr[7:2], 2'h0};
          addr_d[1:0] = haddr[1:0];
          write_d = hwrite;
          size_d = hsize;
          hreadyout_d = 1'b0;
          busState_d = BUS_ACCESS;
        end
      end
      BUS_ACCESS: begin
        hreadyout_d = 1'b1;
        busState_d = BUS_IDLE;
        hrdata_d = 32'h0000_0000;
        if (accessOk) begin
          if (write_q) begin
            case ({addr_q[7:2], 2'h0})
              OFF_EXT_ENABLE: ext_d = (ext_q & ~laneMask) | (hwdata & laneMask);
              OFF_CURSOR_CONTROL: ctrl_d = (ctrl_q & ~laneMask) | (hwdata & laneMask);
              OFF_CURSOR_POSITION: pos_d = (pos_q & ~laneMask) | (hwdata & laneMask);
              OFF_CURSOR_DATA: begin
                ramBus.wrEn = 1'b1;
                ctrl_d[CTRL_PTR_LSB +: RAM_AW] = ptrNext;
              end
              default: ;
            endcase
          end else begin
            case ({addr_q[7:2], 2'h0})
              OFF_EXT_ENABLE: hrdata_d = ext_q;
              OFF_CURSOR_CONTROL: hrdata_d = ctrl_q;
              OFF_CURSOR_POSITION: hrdata_d = pos_q;
              OFF_ACTIVE_POSITION: hrdata_d = activePos_q;
              default: hrdata_d = 32'h0000_0000;
            endcase
          end
        end
      end
      default: begin
        busState_d = BUS_IDLE;
        hreadyout_d = 1'b1;
      end
    endcase
    ext_d = ext_d & (32'h0000_0001 << EXT_EN_BIT);
    ctrl_d = ctrl_d & 32'h0000_FF0F;
    pos_d = pos_d & 32'h07FF_07FF;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busState_q <= BUS_IDLE;
      addr_q <= 8'h00;
      write_q <= 1'b0;
      size_q <= 3'h0;
      hreadyout_q <= 1'b1;
      hrdata_q <= RST_WORD;
      hresp_q <= 1'b0;
      ext_q <= RST_WORD;
      ctrl_q <= RST_WORD;
      pos_q <= RST_WORD;
    end else begin
      busState_q <= busState_d;
      addr_q <= addr_d;
      write_q <= write_d;
      size_q <= size_d;
      hreadyout_q <= hreadyout_d;
      hrdata_q <= hrdata_d;
      hresp_q <= 1'b0;
      ext_q <= ext_d;
      ctrl_q <= ctrl_d;
      pos_q <= pos_d;
    end
  end

  // ------------------------------------------------------------
  // Frame-synchronous position and selection
  // ------------------------------------------------------------
  always_comb begin
    activePos_d = activePos_q;
    activeSel_d = activeSel_q;
    if (vsync && !vsyncPrev_q) begin
      activePos_d = pos_q;
      activeSel_d = ctrl_q[CTRL_SEL_LSB +: 2];
    end
  end

  // ------------------------------------------------------------
  // Pixel pipeline: address stage, then merge stage
  // ------------------------------------------------------------
  always_comb begin
    dx = {1'b0, hPos} - {1'b0, activePos_q[POS_X_LSB +: COORD_W]};
    dy = {1'b0, vPos} - {1'b0, activePos_q[POS_Y_LSB +: COORD_W]};
    side = curSmall ? SMALL_SIDE : LARGE_SIDE;
    inside_d = ctrl_q[CTRL_EN_BIT] && !dx[COORD_W] && !dy[COORD_W] &&
               (dx[COORD_W-1:0] < {4'h0, side}) && (dy[COORD_W-1:0] < {4'h0, side});
    bitIdx_d = 5'h1F - dx[4:0];
    base_d = videoActive ? videoPixel : gfxPixel;
    if (curSmall) begin
      ramBus.rdAddrAnd = {1'b0, activeSel_q, dy[4:0]};
    end else begin
      ramBus.rdAddrAnd = {1'b0, dy[5:0], dx[5]};
    end
    ramBus.rdAddrXor = {1'b1, ramBus.rdAddrAnd[6:0]};
    andBit = ramBus.rdAnd[bitIdx_q];
    xorBit = ramBus.rdXor[bitIdx_q];
    pixelOut_d = base_q;
    if (inside_q) begin
      case ({andBit, xorBit})
        2'b00: pixelOut_d = COLOUR_ZERO;
        2'b01: pixelOut_d = COLOUR_ONE;
        2'b10: pixelOut_d = base_q;
        2'b11: pixelOut_d = ~base_q;
        default: pixelOut_d = base_q;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vsyncPrev_q <= 1'b0;
      activePos_q <= RST_WORD;
      activeSel_q <= 2'h0;
      inside_q <= 1'b0;
      bitIdx_q <= 5'h00;
      base_q <= COLOUR_ZERO;
      pixelOut_q <= COLOUR_ZERO;
    end else begin
      vsyncPrev_q <= vsync;
      activePos_q <= activePos_d;
      activeSel_q <= activeSel_d;
      inside_q <= inside_d;
      bitIdx_q <= bitIdx_d;
      base_q <= base_d;
      pixelOut_q <= pixelOut_d;
    end
  end

endmodule : hardware_cursor_overlay
`default_nettype wire

/* File: verification/hardware_cursor_overlay_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module hardware_cursor_overlay_asserts import cursor_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic [PIX_W-1:0] gfxPixel,
  input wire logic [PIX_W-1:0] videoPixel,
  input wire logic videoActive,
  input wire logic [PIX_W-1:0] pixelOut
);
  // ------------------------------------------------------------
  // Shadow of enable bits
  // ------------------------------------------------------------
  logic take;
  logic [PIX_W-1:0] baseW;
  logic pendWr_q;
  logic [7:0] pendAddr_q;
  logic extEn_q;
  logic curEn_q;
  assign take = hsel && htrans[1] && hready;
  assign baseW = videoActive ? videoPixel : gfxPixel;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pendWr_q <= 1'b0;
      pendAddr_q <= 8'h00;
      extEn_q <= 1'b0;
      curEn_q <= 1'b0;
    end else begin
      pendWr_q <= take && hwrite;
      pendAddr_q <= haddr[7:0];
      if (pendWr_q && pendAddr_q == OFF_EXT_ENABLE) extEn_q <= hwdata[EXT_EN_BIT];
      if (pendWr_q && pendAddr_q == OFF_CURSOR_CONTROL && extEn_q) curEn_q <= hwdata[CTRL_EN_BIT];
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not OKAY");
  property p_wait; take |=> !hreadyout ##1 hreadyout; endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");
  property p_noSpurious; !hreadyout |-> $past(take); endproperty
  a_noSpurious: assert property (p_noSpurious) else $error("hreadyout low without request");
  property p_blocked; take && !hwrite && !extEn_q && haddr[7:0] >= 8'h04 && haddr[7:0] <= 8'h10 |-> ##3 hrdata == 32'h0;
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocked read not zero");
  property p_unmapped; take && !hwrite && haddr[7:0] > 8'h10 |-> ##3 hrdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_dataRd; take && !hwrite && haddr[7:0] == OFF_CURSOR_DATA |-> ##3 hrdata == 32'h0; endproperty
  a_dataRd: assert property (p_dataRd) else $error("data register read not zero");
  property p_hold; hreadyout && $past(hreadyout) |-> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("hrdata changed while idle");
  property p_off; (!curEn_q && $stable(baseW))[*6] |-> pixelOut == baseW; endproperty
  a_off: assert property (p_off) else $error("pixel altered with cursor off");
endmodule : hardware_cursor_overlay_asserts
bind hardware_cursor_overlay hardware_cursor_overlay_asserts i_asserts (.*);
`default_nettype wire

/* File: verification/hardware_cursor_overlay_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module hardware_cursor_overlay_tb_top import cursor_pkg::*; ();
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, vsync = 1'b0, videoActive = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [COORD_W-1:0] hPos = 11'h0, vPos = 11'h0;
  logic [PIX_W-1:0] gfxPixel = 16'h1234, videoPixel = 16'hA5C3, pixelOut;
  int mismatches = 0, cmp_count = 0;
  always #20 clk = ~clk;
  hardware_cursor_overlay i_dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .vsync(vsync), .hPos(hPos), .vPos(vPos), .gfxPixel(gfxPixel), .videoPixel(videoPixel),
    .videoActive(videoActive), .pixelOut(pixelOut));
  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [2:0] sz, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= sz;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, 3'h2, d);
  endtask : wr
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 3'h2, 32'h0);
    chk(nm, exp, rd);
  endtask : rdchk
  task automatic vs();
    @(posedge clk);
    vsync <= 1'b1;
    repeat (2) @(posedge clk);
    vsync <= 1'b0;
  endtask : vs
  task automatic pix(input logic [10:0] x, input logic v, input logic [15:0] exp);
    @(posedge clk);
    hPos <= x;
    videoActive <= v;
    repeat (3) @(posedge clk);
    #1;
    chk("pixelOut", {16'h0, exp}, {16'h0, pixelOut});
  endtask : pix
  task automatic finish_test();
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rdchk("ext", OFF_EXT_ENABLE, 32'h0);
    wr(OFF_CURSOR_CONTROL, 32'h0000_FF01);
    wr(OFF_EXT_ENABLE, 32'h0000_0002);
    rdchk("ext", OFF_EXT_ENABLE, 32'h0000_0002);
    rdchk("ctrl", OFF_CURSOR_CONTROL, 32'h0);
    rdchk("unmapped", 8'h40, 32'h0);
    wr(OFF_CURSOR_CONTROL, 32'h0000_7E00);
    repeat (2) wr(OFF_CURSOR_DATA, 32'h0);
    rdchk("ptr", OFF_CURSOR_CONTROL, 32'h0000_8000);
    rdchk("data", OFF_CURSOR_DATA, 32'h0);
    wr(OFF_CURSOR_CONTROL, 32'h0000_5E02);
    repeat (2) wr(OFF_CURSOR_DATA, 32'h0);
    rdchk("ptr", OFF_CURSOR_CONTROL, 32'h0000_C002);
    xfer(1'b1, OFF_CURSOR_POSITION, 3'h1, 32'h0000_07FF);
    xfer(1'b1, 8'h0A, 3'h1, 32'h0456_0000);
    rdchk("pos", OFF_CURSOR_POSITION, 32'h0456_07FF);
    rdchk("active", OFF_ACTIVE_POSITION, 32'h0);
    vs();
    rdchk("active", OFF_ACTIVE_POSITION, 32'h0456_07FF);
    wr(OFF_CURSOR_CONTROL, 32'h0);
    wr(OFF_CURSOR_DATA, 32'h3000_0000);
    wr(OFF_CURSOR_CONTROL, 32'h0000_8000);
    wr(OFF_CURSOR_DATA, 32'h5000_0000);
    wr(OFF_CURSOR_POSITION, 32'h0);
    vs();
    pix(11'h1, 1'b0, 16'h1234);
    wr(OFF_CURSOR_CONTROL, 32'h1);
    pix(11'h0, 1'b0, 16'h0000);
    pix(11'h1, 1'b0, 16'hFFFF);
    pix(11'h2, 1'b0, 16'h1234);
    pix(11'h3, 1'b0, 16'hEDCB);
    pix(11'h4, 1'b0, 16'h0000);
    pix(11'h3, 1'b1, 16'h5A3C);
    pix(11'h2, 1'b1, 16'hA5C3);
    pix(11'h40, 1'b0, 16'h1234);
    wr(OFF_CURSOR_POSITION, 32'h0000_0002);
    pix(11'h1, 1'b0, 16'hFFFF);
    vs();
    pix(11'h1, 1'b0, 16'h1234);
    pix(11'h3, 1'b0, 16'hFFFF);
    wr(OFF_CURSOR_CONTROL, 32'h0000_2003);
    wr(OFF_CURSOR_DATA, 32'h8000_0000);
    wr(OFF_CURSOR_CONTROL, 32'h0000_A003);
    wr(OFF_CURSOR_DATA, 32'h0000_0000);
    wr(OFF_CURSOR_POSITION, 32'h0);
    wr(OFF_CURSOR_CONTROL, 32'h0000_0007);
    pix(11'h2, 1'b0, 16'h0000);
    vs();
    pix(11'h0, 1'b0, 16'h1234);
    pix(11'h1, 1'b0, 16'h0000);
    pix(11'h20, 1'b0, 16'h1234);
    finish_test();
  end
endmodule : hardware_cursor_overlay_tb_top
`default_nettype wire
